/* File: hw/rupc_pkg.sv */
// package: constants and types for the remote upgrade control block
//======================================================================
// Overview of operation
// - power-up image 0, pin still unsynchronised at boot; input register overrides
// - crc error or watchdog expiry loads other image
// - second error waits, or auto-restart reconfigures
// - config_done, config request, upgrade request start reconfiguration
// - upgrade request acts only while upgrade enabled
// - serial input sampled on upgrade clock in shift
// - serial output shows shift register while shifting
// - falling edge of restart input restarts watchdog
// - registers on upgrade clock, user mode, enabled only
// - update copies shift bits 38:0 into input register
// - capture loads shift register from state source
// - bits 40:39 pick capture source but are never loaded, so capture always takes current state
// - shift mode ignores capture control, shifts each edge
// - watchdog enabled by default, may be disabled
// - watchdog time-out setting defaults to 0xfff
// - encrypted-only option flags unencrypted image error
// - upgrade enabled by default in dual image mode
// - revert cause and failed image reported in status register, never reached by capture
// - shift puts serial input above old bits 38:1
// - input bit 12 enables override, bit 13 chooses
// - watchdog expiry indicates time-out, records, reverts
package rupc_pkg;
   localparam int          SR_W          = 41;
   localparam int          IR_W          = 39;
   localparam int          SEL_HI        = 40;
   localparam int          SEL_LO        = 39;
   localparam int          OVR_EN_BIT    = 12;
   localparam int          OVR_SEL_BIT   = 13;
   localparam int          WD_W          = 29;
   localparam int          WD_SET_W      = 12;
   localparam int          WD_SET_SHIFT  = 17;
   localparam logic [11:0] WD_SET_RST    = 12'hfff;   // upper bits of 0x1fffffff default
   localparam int          ST_MSM_LO     = 30;
   localparam int          ST_WDEN_BIT   = 29;
   localparam int          PV_SRC_LO     = 28;
   localparam int          PV_MSM_LO     = 22;
   localparam logic [31:0] ADDR_CTRL     = 32'h0000_0000;
   localparam logic [31:0] ADDR_STATUS   = 32'h0000_0004;
   localparam logic [31:0] ADDR_WDSET    = 32'h0000_0008;
   localparam int          CTRL_UPG_EN   = 0;
   localparam int          CTRL_WD_EN    = 1;
   localparam int          CTRL_AUTO     = 2;
   localparam int          CTRL_ENC_ONLY = 3;
   localparam int          CTRL_DUAL     = 4;
   localparam int          CTRL_USER     = 5;
   localparam logic [31:0] CTRL_RST      = 32'h0000_0013;
   localparam int          CLK_NS        = 4;
   localparam int          RESTART_MIN_NS = 250;
   localparam int          RESTART_MIN_CYC = (RESTART_MIN_NS + CLK_NS - 1) / CLK_NS;

   typedef enum logic [3:0] {
      RUPC_LOAD0     = 4'h2,
      RUPC_LOAD1_REV = 4'h3,
      RUPC_LOAD1     = 4'h4,
      RUPC_LOAD0_REV = 4'h5
   } rupc_msm_t;
endpackage : rupc_pkg

/* File: hw/rupc_top.sv */
// remote upgrade control: state tracking, watchdog, serial register pair, apb
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module rupc_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic      [31:0] prdata,
   input  wire logic        upgrade_clk,
   input  wire logic        upgrade_serial_in,
   output logic             upgrade_serial_out,
   input  wire logic        shift_not_load,
   input  wire logic        capture_not_update,
   input  wire logic        upgrade_reconfig_req_n,
   input  wire logic        watchdog_restart_n,
   input  wire logic        config_done_pin,
   input  wire logic        config_req_n,
   input  wire logic        image_select_pin,
   input  wire logic        crc_error,
   input  wire logic        image_unencrypted,
   input  wire logic        load_done,
   output logic             reconfig_start,
   output logic             config_error,
   output logic             timeout_pulse,
   output logic             image_sel
);
   import rupc_pkg::*;

   //===================================================================
   // input synchronisers
   logic [7:0] sa_q, sb_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sa_q <= 8'hff;
         sb_q <= 8'hff;
      end else begin
         sa_q <= {upgrade_clk, upgrade_serial_in, shift_not_load, capture_not_update,
                  upgrade_reconfig_req_n, watchdog_restart_n, config_done_pin, config_req_n};
         sb_q <= sa_q;
      end
   end
   logic uclk_s, sin_s, snl_s, cnu_s, ureq_s, wrst_s, cdone_s, creq_s;
   assign {uclk_s, sin_s, snl_s, cnu_s, ureq_s, wrst_s, cdone_s, creq_s} = sb_q;

   logic [3:0] sc_q, sd_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sc_q <= 4'h0;
         sd_q <= 4'h0;
      end else begin
         sc_q <= {image_select_pin, crc_error, image_unencrypted, load_done};
         sd_q <= sc_q;
      end
   end
   logic pin_sel_s, crc_s, unenc_s, done_s;
   assign {pin_sel_s, crc_s, unenc_s, done_s} = sd_q;

   logic [7:0] prev_q;
   logic [3:0] pd_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q <= 8'hff;
         pd_q   <= 4'h0;
      end else begin
         prev_q <= {uclk_s, 1'b0, 1'b0, 1'b0, ureq_s, wrst_s, cdone_s, creq_s};
         pd_q   <= {1'b0, crc_s, 1'b0, done_s};
      end
   end
   logic uclk_rise, wrst_fall, ureq_fall, cdone_fall, creq_fall, crc_rise, done_rise;
   assign uclk_rise  = uclk_s & ~prev_q[7];
   assign ureq_fall  = ~ureq_s & prev_q[3];
   assign wrst_fall  = ~wrst_s & prev_q[2];
   assign cdone_fall = ~cdone_s & prev_q[1];
   assign creq_fall  = ~creq_s & prev_q[0];
   assign crc_rise   = crc_s & ~pd_q[2];
   assign done_rise  = done_s & ~pd_q[0];

   //===================================================================
   // apb registers
   logic [31:0]   ctrl_q;
   logic [11:0]   wdset_q;
   logic          apb_wr;
   assign pready  = 1'b1;
   assign apb_wr  = psel & penable & pwrite;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q  <= CTRL_RST;
         wdset_q <= WD_SET_RST;
      end else if (apb_wr) begin
         if (paddr == ADDR_CTRL) ctrl_q <= {26'h0, pwdata[5:0]};
         if (paddr == ADDR_WDSET) wdset_q <= pwdata[11:0];
      end
   end
   logic upg_en, wd_en, auto_rst, enc_only, user_mode;
   assign upg_en    = ctrl_q[CTRL_UPG_EN] | ctrl_q[CTRL_DUAL];
   assign wd_en     = ctrl_q[CTRL_WD_EN];
   assign auto_rst  = ctrl_q[CTRL_AUTO];
   assign enc_only  = ctrl_q[CTRL_ENC_ONLY];
   assign user_mode = ctrl_q[CTRL_USER];

   //===================================================================
   // master state machine and revert tracking
   rupc_msm_t  msm_q;
   logic       boot_q, loading_q, err_wait_q, waiting_q;
   logic [3:0] cause_q, pmsm_q;
   logic [21:0] pv_rsv;
   logic [WD_W-1:0] wd_q;
   logic       wd_exp, err_ev, ext_trig, sel_next;
   logic [38:0] ir_q;
   assign pv_rsv   = 22'h0;
   assign wd_exp   = wd_en & user_mode & ~loading_q & (wd_q == '0);
   assign err_ev   = (crc_rise & loading_q) | wd_exp;
   assign ext_trig = cdone_fall | creq_fall | (ureq_fall & upg_en);
   // override only once input register bit 12 is set
   assign sel_next = ir_q[OVR_EN_BIT] ? ir_q[OVR_SEL_BIT] : pin_sel_s;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         msm_q      <= RUPC_LOAD0;
         boot_q     <= 1'b1;
         loading_q  <= 1'b1;
         err_wait_q <= 1'b0;
         waiting_q  <= 1'b0;
         cause_q    <= 4'h0;
         pmsm_q     <= 4'h0;
      end else begin
         if (boot_q) begin
            boot_q <= 1'b0;
            msm_q  <= pin_sel_s ? RUPC_LOAD1 : RUPC_LOAD0;
         end else if (done_rise) begin
            loading_q <= 1'b0;
         end
         if (!boot_q && (err_ev || ext_trig)) begin
            // tie order: config request, crc, config_done, watchdog
            cause_q <= creq_fall ? 4'h8 : crc_rise ? 4'h4 : cdone_fall ? 4'h2
                     : wd_exp ? 4'h1 : 4'h0;
            pmsm_q  <= msm_q;
            if (ext_trig) begin
               loading_q  <= 1'b1;
               err_wait_q <= 1'b0;
               waiting_q  <= 1'b0;
               msm_q      <= sel_next ? RUPC_LOAD1 : RUPC_LOAD0;
            end else if (err_wait_q && !auto_rst) begin
               waiting_q <= 1'b1;
            end else begin
               loading_q  <= 1'b1;
               err_wait_q <= 1'b1;
               unique case (msm_q)
                  RUPC_LOAD0, RUPC_LOAD0_REV: msm_q <= RUPC_LOAD1_REV;
                  RUPC_LOAD1, RUPC_LOAD1_REV: msm_q <= RUPC_LOAD0_REV;
               endcase
            end
         end
      end
   end

   //===================================================================
   // watchdog
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_q <= {WD_SET_RST, {WD_SET_SHIFT{1'b1}}};
      end else if (loading_q || wrst_fall || wd_exp) begin
         wd_q <= {wdset_q, {WD_SET_SHIFT{1'b1}}};
      end else if (wd_en && user_mode) begin
         wd_q <= wd_q - 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reconfig_start <= 1'b0;
         timeout_pulse  <= 1'b0;
         config_error   <= 1'b0;
         image_sel      <= 1'b0;
      end else begin
         reconfig_start <= !boot_q && (ext_trig || (err_ev && !(err_wait_q && !auto_rst)));
         timeout_pulse  <= wd_exp;
         config_error   <= (enc_only & unenc_s & loading_q) | (config_error & ~done_rise);
         image_sel      <= (msm_q == RUPC_LOAD1) || (msm_q == RUPC_LOAD1_REV);
      end
   end

   //===================================================================
   // shift and input registers on upgrade clock edges
   logic [SR_W-1:0] sr_q;
   logic            ru_act;
   logic [38:0]     cur_st, prev_st;
   assign ru_act  = uclk_rise & user_mode & upg_en;
   assign cur_st  = {5'h0, msm_q, wd_en, wd_q};
   assign prev_st = {8'h0, cause_q, 2'b00, pmsm_q, pv_rsv[21:1]};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sr_q <= '0;
         ir_q <= '0;
      end else if (ru_act) begin
         if (snl_s) begin
            sr_q <= {sr_q[SR_W-1:IR_W], sin_s, sr_q[38:1]};
         end else if (!cnu_s) begin
            ir_q <= sr_q[38:0];
         end else begin
            unique case ({sr_q[SEL_HI], sr_q[SEL_LO]})
               2'b00: sr_q[38:0] <= cur_st;
               2'b01: sr_q[38:0] <= prev_st;
               2'b10: sr_q[38:0] <= prev_st;
               2'b11: sr_q[38:0] <= ir_q;
            endcase
         end
      end
   end
   assign upgrade_serial_out = sr_q[0];

   //===================================================================
   // register read back
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0;
      end else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            ADDR_CTRL:   prdata <= ctrl_q;
            ADDR_STATUS: prdata <= {msm_q, wd_en, waiting_q, cause_q, pmsm_q, sr_q[40:23]};
            ADDR_WDSET:  prdata <= {20'h0, wdset_q};
            default:     prdata <= 32'h0;
         endcase
      end
   end
   assign pslverr = psel & penable &
                    ~((paddr == ADDR_CTRL) | (paddr == ADDR_STATUS) | (paddr == ADDR_WDSET));

   //===================================================================
   // checks
   chk_wd_restart: assert property (@(posedge pclk) disable iff (!presetn)
      wrst_fall && !wd_exp |=> wd_q == {wdset_q, {WD_SET_SHIFT{1'b1}}})
      else $error("watchdog not restarted");
   chk_timeout_rec: assert property (@(posedge pclk) disable iff (!presetn)
      wd_exp && !boot_q && !ext_trig && !(err_wait_q && !auto_rst) |=> timeout_pulse && loading_q)
      else $error("timeout not recorded");
   chk_shift_dir: assert property (@(posedge pclk) disable iff (!presetn)
      ru_act && snl_s |=> sr_q[37:0] == $past(sr_q[38:1]))
      else $error("shift direction wrong");
   chk_update_ir: assert property (@(posedge pclk) disable iff (!presetn)
      ru_act && !snl_s && !cnu_s |=> ir_q == $past(sr_q[38:0]) && $stable(sr_q))
      else $error("update wrong");
   chk_ir_hold: assert property (@(posedge pclk) disable iff (!presetn)
      ru_act && (snl_s || cnu_s) |=> $stable(ir_q))
      else $error("input register changed");
   chk_req_gate: assert property (@(posedge pclk) disable iff (!presetn)
      ureq_fall && !upg_en && !cdone_fall && !creq_fall && !err_ev |=> !reconfig_start)
      else $error("request acted while disabled");
   chk_no_act: assert property (@(posedge pclk) disable iff (!presetn)
      !user_mode |=> $stable(ir_q))
      else $error("register moved outside user mode");
   chk_wait_err: assert property (@(posedge pclk) disable iff (!presetn)
      err_ev && err_wait_q && !auto_rst && !ext_trig && !boot_q |=> waiting_q && $stable(msm_q))
      else $error("second error not waiting");
   chk_enc_error: assert property (@(posedge pclk) disable iff (!presetn)
      enc_only && unenc_s && loading_q |=> config_error)
      else $error("unencrypted image not flagged");
   chk_image_override: assert property (@(posedge pclk) disable iff (!presetn)
      ext_trig && !boot_q |=> ((msm_q == RUPC_LOAD1) || (msm_q == RUPC_LOAD1_REV)) == $past(sel_next))
      else $error("image choice not taken");
   chk_capture_cur: assert property (@(posedge pclk) disable iff (!presetn)
      ru_act && !snl_s && cnu_s && !sr_q[SEL_HI] && !sr_q[SEL_LO] |=> sr_q[38:0] == $past(cur_st))
      else $error("current state not captured");
endmodule : rupc_top
`default_nettype wire

/* File: test/rupc_link_model.sv */
// partner model: user logic that works the upgrade link
`timescale 1ns/100ps
`default_nettype none
module rupc_link_model (
   output logic      upgrade_clk,
   output logic      upgrade_serial_in,
   output logic      shift_not_load,
   output logic      capture_not_update,
   input  wire logic upgrade_serial_out
);
   //======================================================================
   // idle levels; the link clock stands low outside frames
   initial begin
      upgrade_clk        = 1'b0;
      upgrade_serial_in  = 1'b0;
      shift_not_load     = 1'b0;
      capture_not_update = 1'b0;
   end

   //======================================================================
   // one link clock of 48 ns per call
   // modes settle half a period before the rise and hold past the detect delay
   task automatic edge_op(input logic snl, input logic cnu, input logic din,
                          output logic dout);
      shift_not_load     = snl;
      capture_not_update = cnu;
      upgrade_serial_in  = din;
      #24;
      dout        = upgrade_serial_out;
      upgrade_clk = 1'b1;
      #24;
      upgrade_clk       = 1'b0;
      // a released data line shows the inverse, so a stale bit is never read as good
      upgrade_serial_in = ~din;
   endtask : edge_op
endmodule : rupc_link_model
`default_nettype wire

/* File: test/tb.sv */
// testbench: register, link and revert checks against expected values
`timescale 1ns/100ps
`default_nettype none
module tb;
   import rupc_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, bit_o;
   logic [31:0] paddr, pwdata, prdata, rnd, rv;
   logic        upgrade_clk, upgrade_serial_in, upgrade_serial_out, shift_not_load;
   logic        capture_not_update, upgrade_reconfig_req_n, watchdog_restart_n;
   logic        config_req_n, image_select_pin, crc_error, image_unencrypted, load_done;
   logic        reconfig_start, config_error, image_sel, timeout_pulse, config_done_pin;
   logic [38:0] wa, got;
   logic        q[$];
   int          n_mismatch, tests_run, n_start, exp_start, cyc;

   rupc_top dut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
      .upgrade_clk, .upgrade_serial_in, .upgrade_serial_out, .shift_not_load,
      .capture_not_update, .upgrade_reconfig_req_n, .watchdog_restart_n,
      .config_done_pin, .config_req_n, .image_select_pin, .crc_error,
      .image_unencrypted, .load_done, .reconfig_start, .config_error,
      .timeout_pulse, .image_sel
   );
   rupc_link_model link (
      .upgrade_clk, .upgrade_serial_in, .shift_not_load, .capture_not_update,
      .upgrade_serial_out
   );

   //======================================================================
   // clock, pulse counter and hang guard
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (reconfig_start === 1'b1) n_start <= n_start + 1;
      if (cyc == 30000) begin
         n_mismatch = n_mismatch + 1;
         close_out;
      end
   end

   //======================================================================
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
      rv = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rv, e);
   endtask : rd
   // bit k of the idle-relative mask marks the input being pulsed
   task automatic pulse(input int k, input int len);
      @(posedge pclk);
      {load_done, crc_error, watchdog_restart_n, config_req_n, upgrade_reconfig_req_n}
         <= (5'h1 << k) ^ 5'h07;
      repeat (len) @(posedge pclk);
      {load_done, crc_error, watchdog_restart_n, config_req_n, upgrade_reconfig_req_n}
         <= 5'h07;
   endtask : pulse
   task automatic wait_start;
      int n;
      n = 0;
      while (n_start != exp_start && n < 100) begin @(posedge pclk); n++; end
      repeat (4) @(posedge pclk);
      chk(n_start, exp_start);
   endtask : wait_start
   task automatic close_out;
      $display("counts: %0d compared, %0d wrong", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : close_out

   //======================================================================
   // main sequence
   initial begin
      rnd = 32'h1051ac34;
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 32'h0; pwdata = 32'h0; image_select_pin = 1'b0; image_unencrypted = 1'b0;
      config_done_pin = 1'b1;
      {load_done, crc_error, watchdog_restart_n, config_req_n, upgrade_reconfig_req_n} = 5'h07;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(ADDR_CTRL, CTRL_RST);
      rd(ADDR_WDSET, {20'h0, WD_SET_RST});
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rv[ST_WDEN_BIT], 1'b1);
      rd(32'h0000_000c, 32'h0);
      chk(err, 1'b1);
      rnd = lfsr(rnd);
      apb(1'b1, ADDR_WDSET, rnd);
      rd(ADDR_WDSET, {20'h0, rnd[11:0]});
      apb(1'b1, ADDR_WDSET, 32'hfff);
      chk(image_sel, 1'b0);
      $display("test registers done");
      // upgrade off: request must be ignored
      apb(1'b1, ADDR_CTRL, 32'h20);
      pulse(0, 8);
      repeat (20) @(posedge pclk);
      chk(n_start, exp_start);
      $display("test request disabled done");
      apb(1'b1, ADDR_CTRL, 32'h33);
      pulse(2, RESTART_MIN_CYC);
      for (int j = 0; j < 2; j++) begin
         rnd = lfsr(rnd);
         wa  = {rnd, rnd[6:0]} | 39'h3000;
         for (int i = 0; i < 39; i++) begin
            link.edge_op(1'b1, 1'b0, wa[i], bit_o);
            if (j == 1) chk(bit_o, q.pop_front());
            q.push_back(wa[i]);
         end
      end
      link.edge_op(1'b0, 1'b0, 1'b0, bit_o);
      link.edge_op(1'b0, 1'b1, 1'b0, bit_o);
      for (int i = 0; i < 39; i++) begin
         link.edge_op(1'b1, 1'b0, 1'b0, bit_o);
         got[i] = bit_o;
      end
      chk(got[38:29], {5'h0, RUPC_LOAD0, 1'b1});
      $display("test link done");
      exp_start++;
      pulse(0, 8);
      wait_start;
      chk(image_sel, 1'b1);
      exp_start++;
      pulse(3, 8);
      wait_start;
      chk(image_sel, 1'b0);
      pulse(4, 8);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk({rv[31:28], rv[25:18]}, {RUPC_LOAD0_REV, 4'h4, RUPC_LOAD1});
      $display("test revert done");
      apb(1'b1, ADDR_CTRL, 32'h3b);
      exp_start++;
      pulse(1, 8);
      wait_start;
      image_unencrypted <= 1'b1;
      repeat (8) @(posedge pclk);
      chk(config_error, 1'b1);
      image_unencrypted <= 1'b0;
      pulse(4, 8);
      repeat (8) @(posedge pclk);
      chk(config_error, 1'b0);
      $display("test encrypted only done");
      // status pin pulled low from outside must start a reconfiguration
      config_done_pin <= 1'b0;
      exp_start++;
      wait_start;
      config_done_pin <= 1'b1;
      chk(timeout_pulse, 1'b0);
      $display("test status pin done");
      close_out;
   end
endmodule : tb
`default_nettype wire
